// ==== design/hbu_fifo.sv ====
// Flip-flop FIFO with flush, registered ready and fill count.
// Assumes pop only while out_valid and push only while in_ready_r.
`timescale 1ns/1ps
module hbu_fifo #(
   parameter int unsigned W     = 8,
   parameter int unsigned DEPTH = 512
) (
   // Clock and reset
   input  wire logic                       clock,
   input  wire logic                       reset,
   input  wire logic                       flush,
   // Fill side
   input  wire logic                       in_valid,
   input  wire logic [W-1:0]               in_data,
   output logic                            in_ready_r,
   // Drain side
   input  wire logic                       out_pop,
   output logic [W-1:0]                    out_data,
   output logic                            out_valid_r,
   output logic [$clog2(DEPTH+1)-1:0]      count_r
);
   localparam int unsigned AW = $clog2(DEPTH);
   localparam int unsigned CW = $clog2(DEPTH+1);

   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wr_r;
   logic [AW-1:0] rd_r;
   logic          push;
   logic          pop;
   logic [CW-1:0] cnt_nxt;

   assign push     = in_valid && in_ready_r;
   assign pop      = out_pop && out_valid_r;
   assign out_data = mem[rd_r];
   assign cnt_nxt  = count_r + CW'(push) - CW'(pop);

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_r] <= in_data;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         wr_r        <= '0;
         rd_r        <= '0;
         count_r     <= '0;
         in_ready_r  <= 1'b1;
         out_valid_r <= 1'b0;
      end else if (flush) begin
         wr_r        <= '0;
         rd_r        <= '0;
         count_r     <= '0;
         in_ready_r  <= 1'b1;
         out_valid_r <= 1'b0;
      end else begin
         if (push) wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
         if (pop) rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
         count_r     <= cnt_nxt;
         in_ready_r  <= cnt_nxt != CW'(DEPTH);
         out_valid_r <= cnt_nxt != '0;
      end
   end
endmodule : hbu_fifo

// ==== design/hbu_pkg.sv ====
// Shared types and constants of the bridge serial datapath.
// Assumes one 250 MHz core clock; all users import the whole package.
package hbu_pkg;
   localparam int unsigned FIFO_DEPTH    = 512;
   localparam int unsigned BAUD_W        = 16;
   localparam int unsigned OVERSAMPLE    = 16;
   localparam logic [3:0]  PH_LAST       = 4'hf;
   localparam logic [3:0]  PH_MID        = 4'h7;
   localparam logic [3:0]  BITS_MIN      = 4'h5;
   localparam logic [3:0]  BITS_BYTE     = 4'h8;
   localparam logic [3:0]  BITS_WIDE     = 4'h9;
   localparam logic [7:0]  RPT_STATUS    = 8'h42;
   localparam logic [7:0]  RPT_XFER_MODE = 8'h48;
   // Wide-mode status byte layout
   localparam int unsigned ST_PAR_OR_9TH = 0;
   localparam int unsigned ST_FRAME      = 1;
   localparam int unsigned ST_OVERRUN    = 2;
   localparam int unsigned ST_BREAK      = 3;
   localparam logic        WIDE_RST      = 1'b0;

   typedef struct packed {
      logic [3:0]        data_bits;
      logic              parity_en;
      logic              parity_odd;
      logic              two_stop;
      logic [BAUD_W-1:0] baud_div;
   } hbu_cfg_t;

   typedef struct packed {
      logic valid;
      logic [7:0] id;
      logic wide;
   } hbu_rpt_t;

   typedef struct packed {
      logic brk;
      logic overrun;
      logic frame;
      logic parity;
   } hbu_err_t;

   typedef enum logic [2:0] {T_IDLE, T_SEC, T_START, T_DATA, T_PAR, T_STOP} hbu_tx_st_t;
   typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP, R_PUSH1, R_PUSH2}
      hbu_rx_st_t;
endpackage : hbu_pkg

// ==== design/hbu_tick_gen.sv ====
// Oversample enable: one-cycle pulse every div+1 core cycles.
// Assumes div is stable; restart realigns the divider.
`timescale 1ns/1ps
module hbu_tick_gen #(
   parameter int unsigned W = 16
) (
   // Clock and reset
   input  wire logic         clock,
   input  wire logic         reset,
   input  wire logic         restart,
   // Rate
   input  wire logic [W-1:0] div,
   output logic              tick_r
);
   logic [W-1:0] cnt_r;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         cnt_r  <= '0;
         tick_r <= 1'b0;
      end else if (restart) begin
         cnt_r  <= '0;
         tick_r <= 1'b0;
      end else if (cnt_r >= div) begin
         cnt_r  <= '0;
         tick_r <= 1'b1;
      end else begin
         cnt_r  <= cnt_r + 1'b1;
         tick_r <= 1'b0;
      end
   end
endmodule : hbu_tick_gen

// ==== design/hbu_uart_core.sv ====
// Serial transmit and receive datapath of the report-based bridge.
// Assumes report decoding upstream; config is static while frames run.
`timescale 1ns/1ps
module hbu_uart_core
   import hbu_pkg::*;
#(
   parameter int unsigned DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   input  wire logic       soft_reset,
   input  wire logic       bus_reset,
   input  wire logic       otp_global_lock,
   output logic            otp_wr_block_r,
   output logic            reenum_r,
   // Configuration and reports
   input  wire hbu_cfg_t   cfg,
   input  wire hbu_rpt_t   rpt,
   output logic            wide_r,
   output logic            stat_valid_r,
   output hbu_err_t        stat_r,
   // Transmit payload
   input  wire logic       tx_rpt_ok,
   input  wire logic       tx_wr_valid,
   input  wire logic [7:0] tx_wr_data,
   output logic            tx_wr_ready_r,
   // Receive drain
   input  wire logic       rx_rd_req,
   output logic            rx_rd_valid_r,
   output logic            rx_rd_nak_r,
   output logic [7:0]      rx_rd_data_r,
   // Serial pins
   input  wire logic       rx,
   output logic            tx_r
);
   localparam int unsigned CW = $clog2(DEPTH+1);

   logic          flush;
   logic          tick;
   logic          lock_done_r;
   hbu_tx_st_t    tst_r;
   hbu_rx_st_t    rst_r;
   // Transmit side
   logic          txf_pop;
   logic [7:0]    txf_data;
   logic          txf_valid;
   logic [8:0]    tsh_r;
   logic          tpar_r;
   logic [3:0]    tph_r;
   logic [3:0]    tcnt_r;
   logic          tstop2_r;
   logic          tbit_end;
   logic [3:0]    tbits;
   logic          tpar_on;
   logic [7:0]    tmask;
   // Receive side
   logic [8:0]    rsh_r;
   logic [3:0]    rph_r;
   logic [3:0]    rcnt_r;
   logic          rpar_r;
   logic          rsample;
   logic          rpar_on;
   logic [8:0]    rchar;
   logic [7:0]    rdata_r;
   logic [7:0]    rstat_r;
   logic          pend_ovr_r;
   logic [CW-1:0] rxf_count;
   logic          rxf_wv;
   logic [7:0]    rxf_wd;
   logic          rxf_pop;
   logic [7:0]    rxf_data;
   logic          rxf_valid;
   logic          room_ok;
   hbu_err_t      sticky_r;
   hbu_err_t      ev;
   logic          ev_valid;
   logic          is_query;

   assign flush = soft_reset || bus_reset;

   // Captures the lock flag once after hardware reset releases
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         lock_done_r    <= 1'b0;
         otp_wr_block_r <= 1'b0;
      end else if (!lock_done_r) begin
         lock_done_r    <= 1'b1;
         otp_wr_block_r <= otp_global_lock;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) reenum_r <= 1'b0;
      else reenum_r <= flush;
   end

   // Mode register survives soft and bus resets
   always_ff @(posedge clock or posedge reset) begin
      if (reset) wide_r <= WIDE_RST;
      else if (rpt.valid && rpt.id == RPT_XFER_MODE) wide_r <= rpt.wide;
   end

   hbu_tick_gen #(.W(BAUD_W)) u_tick (
      .clock   (clock),
      .reset   (reset),
      .restart (flush),
      .div     (cfg.baud_div),
      .tick_r  (tick)
   );

   hbu_fifo #(.W(8), .DEPTH(DEPTH)) u_txf (
      .clock       (clock),
      .reset       (reset),
      .flush       (flush),
      .in_valid    (tx_wr_valid && tx_rpt_ok),
      .in_data     (tx_wr_data),
      .in_ready_r  (tx_wr_ready_r),
      .out_pop     (txf_pop),
      .out_data    (txf_data),
      .out_valid_r (txf_valid),
      .count_r     ()
   );

   // Ninth bit only goes out in wide mode; parity never with 9 bits
   assign tbits = (cfg.data_bits == BITS_WIDE && !wide_r) ? BITS_BYTE : cfg.data_bits;
   assign tpar_on  = cfg.parity_en && cfg.data_bits != BITS_WIDE;
   assign tmask    = (cfg.data_bits >= BITS_BYTE) ? 8'hff : 8'(8'hff >> (4'h8 - cfg.data_bits));
   assign tbit_end = tick && tph_r == PH_LAST;
   assign txf_pop  = txf_valid && (tst_r == T_IDLE || tst_r == T_SEC);

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         tst_r    <= T_IDLE;
         tx_r     <= 1'b1;
         tsh_r    <= '0;
         tpar_r   <= 1'b0;
         tph_r    <= '0;
         tcnt_r   <= '0;
         tstop2_r <= 1'b0;
      end else if (flush) begin
         tst_r    <= T_IDLE;
         tx_r     <= 1'b1;
         tph_r    <= '0;
         tcnt_r   <= '0;
         tstop2_r <= 1'b0;
      end else begin
         if (tick) tph_r <= tph_r + 1'b1;
         unique case (tst_r)
            T_IDLE: begin
               tx_r <= 1'b1;
               if (txf_valid) begin
                  tsh_r  <= {1'b0, txf_data & tmask};
                  tpar_r <= ^(txf_data & tmask) ^ cfg.parity_odd;
                  if (wide_r) begin
                     tst_r <= T_SEC;
                  end else begin
                     tst_r <= T_START;
                     tx_r  <= 1'b0;
                     tph_r <= '0;
                  end
               end
            end
            T_SEC: begin
               if (txf_valid) begin
                  // Second byte: only bit 0 is kept
                  if (cfg.data_bits == BITS_WIDE) tsh_r[8] <= txf_data[0];
                  else tpar_r <= txf_data[0];
                  tst_r <= T_START;
                  tx_r  <= 1'b0;
                  tph_r <= '0;
               end
            end
            T_START: begin
               if (tbit_end) begin
                  tx_r   <= tsh_r[0];
                  tsh_r  <= tsh_r >> 1;
                  tcnt_r <= 4'h1;
                  tst_r  <= T_DATA;
               end
            end
            T_DATA: begin
               if (tbit_end) begin
                  if (tcnt_r == tbits) begin
                     tstop2_r <= 1'b0;
                     if (tpar_on) begin
                        tx_r  <= tpar_r;
                        tst_r <= T_PAR;
                     end else begin
                        tx_r  <= 1'b1;
                        tst_r <= T_STOP;
                     end
                  end else begin
                     tx_r   <= tsh_r[0];
                     tsh_r  <= tsh_r >> 1;
                     tcnt_r <= tcnt_r + 1'b1;
                  end
               end
            end
            T_PAR: begin
               if (tbit_end) begin
                  tx_r  <= 1'b1;
                  tst_r <= T_STOP;
               end
            end
            T_STOP: begin
               if (tbit_end) begin
                  if (cfg.two_stop && !tstop2_r) tstop2_r <= 1'b1;
                  else tst_r <= T_IDLE;
               end
            end
         endcase
      end
   end

   assign rsample = tick && rph_r == PH_LAST;
   assign rpar_on = cfg.parity_en && cfg.data_bits != BITS_WIDE;
   // Bits arrive at the top; align the character to bit 0
   assign rchar   = rsh_r >> (4'h9 - cfg.data_bits);
   assign room_ok = wide_r ? (rxf_count <= CW'(DEPTH-2)) : (rxf_count <= CW'(DEPTH-1));

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rst_r      <= R_IDLE;
         rsh_r      <= '0;
         rph_r      <= '0;
         rcnt_r     <= '0;
         rpar_r     <= 1'b0;
         rdata_r    <= '0;
         rstat_r    <= '0;
         pend_ovr_r <= 1'b0;
      end else if (flush) begin
         rst_r      <= R_IDLE;
         rph_r      <= '0;
         rcnt_r     <= '0;
         pend_ovr_r <= 1'b0;
      end else begin
         if (tick) rph_r <= rph_r + 1'b1;
         unique case (rst_r)
            R_IDLE: begin
               if (!rx) begin
                  rst_r <= R_START;
                  rph_r <= '0;
               end
            end
            R_START: begin
               if (tick && rph_r == PH_MID) begin
                  rph_r  <= '0;
                  rcnt_r <= '0;
                  rst_r  <= rx ? R_IDLE : R_DATA;
               end
            end
            R_DATA: begin
               if (rsample) begin
                  rsh_r  <= {rx, rsh_r[8:1]};
                  rcnt_r <= rcnt_r + 1'b1;
                  if (rcnt_r + 1'b1 == cfg.data_bits) rst_r <= rpar_on ? R_PAR : R_STOP;
               end
            end
            R_PAR: begin
               if (rsample) begin
                  rpar_r <= rx;
                  rst_r  <= R_STOP;
               end
            end
            R_STOP: begin
               if (rsample) begin
                  rdata_r <= rchar[7:0];
                  rstat_r <= {4'h0, ev.brk, ev.overrun, ev.frame,
                              cfg.data_bits == BITS_WIDE ? rchar[8] : ev.parity};
                  if (room_ok) begin
                     rst_r      <= R_PUSH1;
                     pend_ovr_r <= 1'b0;
                  end else begin
                     rst_r      <= R_IDLE;
                     pend_ovr_r <= 1'b1;
                  end
               end
            end
            R_PUSH1: rst_r <= wide_r ? R_PUSH2 : R_IDLE;
            R_PUSH2: rst_r <= R_IDLE;
         endcase
      end
   end

   // Errors of the character being closed by its stop sample
   always_comb begin
      ev         = '0;
      ev.frame   = !rx;
      ev.parity  = rpar_on && (rpar_r != (^rchar[7:0] ^ cfg.parity_odd));
      ev.brk     = !rx && rchar == '0 && !(rpar_on && rpar_r);
      ev.overrun = pend_ovr_r || !room_ok;
      ev_valid   = rst_r == R_STOP && rsample;
   end

   // First entry is data; wide mode adds the status byte
   assign rxf_wv = rst_r == R_PUSH1 || rst_r == R_PUSH2;
   assign rxf_wd = (rst_r == R_PUSH2) ? rstat_r : rdata_r;

   hbu_fifo #(.W(8), .DEPTH(DEPTH)) u_rxf (
      .clock       (clock),
      .reset       (reset),
      .flush       (flush),
      .in_valid    (rxf_wv),
      .in_data     (rxf_wd),
      .in_ready_r  (),
      .out_pop     (rxf_pop),
      .out_data    (rxf_data),
      .out_valid_r (rxf_valid),
      .count_r     (rxf_count)
   );

   assign rxf_pop = rx_rd_req && rxf_valid;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rx_rd_valid_r <= 1'b0;
         rx_rd_nak_r   <= 1'b0;
         rx_rd_data_r  <= '0;
      end else begin
         rx_rd_valid_r <= rxf_pop && !flush;
         rx_rd_nak_r   <= rx_rd_req && !rxf_valid && !flush;
         if (rxf_pop) rx_rd_data_r <= rxf_data;
      end
   end

   // Sticky errors for the status query; a new event wins over the clear
   assign is_query = rpt.valid && rpt.id == RPT_STATUS;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sticky_r     <= '0;
         stat_r       <= '0;
         stat_valid_r <= 1'b0;
      end else begin
         stat_valid_r <= is_query;
         if (is_query) begin
            stat_r   <= sticky_r | (ev_valid ? ev : '0);
            sticky_r <= ev_valid ? ev : '0;
         end else if (flush) begin
            sticky_r <= '0;
         end else if (ev_valid) begin
            sticky_r <= sticky_r | ev;
         end
      end
   end
endmodule : hbu_uart_core

// ==== tb/hbu_core_properties.sv ====
// Checker for the serial core: port timing of reads, reports, flushes and lock capture.
// Assumes one clock domain; bound to every hbu_uart_core instance.
`timescale 1ns/1ps
module hbu_core_chk
   import hbu_pkg::*;
(
   // Clock and resets
   input wire logic     clock,
   input wire logic     reset,
   input wire logic     soft_reset,
   input wire logic     bus_reset,
   input wire logic     otp_global_lock,
   input wire logic     otp_wr_block_r,
   input wire logic     reenum_r,
   // Reports
   input wire hbu_rpt_t rpt,
   input wire logic     wide_r,
   input wire logic     stat_valid_r,
   // Drain and pins
   input wire logic     rx_rd_req,
   input wire logic     rx_rd_valid_r,
   input wire logic     rx_rd_nak_r,
   input wire logic     rx,
   input wire logic     tx_r
);
   logic seen_r;
   wire  flush = soft_reset | bus_reset;
   wire  qry   = rpt.valid && rpt.id == RPT_STATUS;
   wire  mode  = rpt.valid && rpt.id == RPT_XFER_MODE;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) seen_r <= 1'b0;
      else seen_r <= 1'b1;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   a_lock_capture: assert property (
      !seen_r |=> otp_wr_block_r == $past(otp_global_lock))
      else $error("lock not captured after reset");
   a_lock_hold: assert property (seen_r |=> $stable(otp_wr_block_r))
      else $error("write block changed");
   a_rd_answer: assert property (
      rx_rd_req && !flush |=> rx_rd_valid_r != rx_rd_nak_r)
      else $error("read request not answered once");
   a_rd_unasked: assert property (rx_rd_valid_r || rx_rd_nak_r |-> $past(rx_rd_req))
      else $error("read answer without request");
   a_stat_reply: assert property (qry |=> stat_valid_r)
      else $error("status query not answered");
   a_mode_set: assert property (mode |=> wide_r == $past(rpt.wide))
      else $error("wide flag not taken");
   a_mode_hold: assert property (!mode |=> $stable(wide_r))
      else $error("wide flag changed");
   a_reenum_pulse: assert property (1'b1 |=> reenum_r == $past(flush))
      else $error("re-enumerate pulse wrong");
   a_flush_empty: assert property (
      (flush && rx) ##1 (rx_rd_req && !flush) |=> rx_rd_nak_r)
      else $error("receive store not emptied");
   a_flush_idle: assert property (flush |-> ##[1:2] tx_r)
      else $error("transmit line not idle after flush");
endmodule : hbu_core_chk

bind hbu_uart_core hbu_core_chk u_chk (.clock(clock), .reset(reset), .soft_reset(soft_reset),
   .bus_reset(bus_reset), .otp_global_lock(otp_global_lock), .otp_wr_block_r(otp_wr_block_r),
   .reenum_r(reenum_r), .rpt(rpt), .wide_r(wide_r), .stat_valid_r(stat_valid_r),
   .rx_rd_req(rx_rd_req), .rx_rd_valid_r(rx_rd_valid_r), .rx_rd_nak_r(rx_rd_nak_r),
   .rx(rx), .tx_r(tx_r));

// ==== tb/hbu_peer.sv ====
// Remote serial port: decodes frames seen on TX and sends frames into RX.
// Assumes a bit time of BIT core cycles; frame edges follow the core clock.
`timescale 1ns/1ps
module hbu_peer #(
   parameter int BIT = 16
) (
   // Clock
   input wire logic       clock,
   // Serial pins
   input wire logic       tx,
   output logic           rx,
   // Decoder length and result
   input wire logic [3:0] nbits,
   output logic [10:0]    frame_r,
   output logic           frame_valid_r
);
   // Samples mid-bit: data LSB first, then the first stop bit above them
   initial begin
      rx = 1'b1;
      frame_valid_r = 1'b0;
      frame_r = 11'h000;
      forever begin
         @(negedge tx);
         frame_r = 11'h000;
         repeat (BIT / 2) @(posedge clock);
         for (int i = 0; i <= nbits; i++) begin
            repeat (BIT) @(posedge clock);
            frame_r[i] = tx;
         end
         #1 frame_valid_r = 1'b1;
         @(posedge clock);
         #1 frame_valid_r = 1'b0;
      end
   end

   task automatic send(input logic [9:0] bits, input int n, input logic stop);
      @(posedge clock);
      #1 rx = 1'b0;
      for (int i = 0; i <= n; i++) begin
         repeat (BIT) @(posedge clock);
         #1 rx = (i == n) ? stop : bits[i];
      end
      repeat (BIT) @(posedge clock);
      #1 rx = 1'b1;
      repeat (BIT) @(posedge clock);
   endtask : send
endmodule : hbu_peer

// ==== tb/hbu_uart_core_test.sv ====
// Self-checking bench: transmit frames, receive storage, status, flushes.
// Assumes baud_div 0, so one bit is 16 core cycles.
`timescale 1ns/1ps
module hbu_uart_core_test
   import hbu_pkg::*;
;
   localparam int BIT = 16;
   logic        clock, reset, soft_reset, bus_reset, otp_global_lock, otp_wr_block_r;
   logic        reenum_r, wide_r, stat_valid_r, tx_rpt_ok, tx_wr_valid, tx_wr_ready_r;
   logic        rx_rd_req, rx_rd_valid_r, rx_rd_nak_r, rx, tx_r, frame_valid_r;
   logic [7:0]  tx_wr_data, rx_rd_data_r;
   logic [3:0]  nbits;
   logic [10:0] frame_r, tx_q[$], rd_q[$], st_q[$];
   hbu_cfg_t    cfg;
   hbu_rpt_t    rpt;
   hbu_err_t    stat_r;
   int          bad_count, checks_done, cyc;

   hbu_uart_core u_dut (.clock(clock), .reset(reset), .soft_reset(soft_reset),
      .bus_reset(bus_reset), .otp_global_lock(otp_global_lock),
      .otp_wr_block_r(otp_wr_block_r), .reenum_r(reenum_r), .cfg(cfg), .rpt(rpt),
      .wide_r(wide_r), .stat_valid_r(stat_valid_r), .stat_r(stat_r), .tx_rpt_ok(tx_rpt_ok),
      .tx_wr_valid(tx_wr_valid), .tx_wr_data(tx_wr_data), .tx_wr_ready_r(tx_wr_ready_r),
      .rx_rd_req(rx_rd_req), .rx_rd_valid_r(rx_rd_valid_r), .rx_rd_nak_r(rx_rd_nak_r),
      .rx_rd_data_r(rx_rd_data_r), .rx(rx), .tx_r(tx_r));
   hbu_peer #(.BIT(BIT)) u_peer (.clock(clock), .tx(tx_r), .rx(rx), .nbits(nbits),
      .frame_r(frame_r), .frame_valid_r(frame_valid_r));

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   task automatic cmp(input string what, input logic [10:0] exp, input logic [10:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp

   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : test_done

   task automatic chk_frame(input logic [10:0] exp);
      cmp("tx_frame", exp, frame_r);
   endtask : chk_frame

   task automatic chk_read(input logic [10:0] exp);
      cmp("rx_read", exp, {2'b00, rx_rd_nak_r, rx_rd_data_r & {8{~rx_rd_nak_r}}});
   endtask : chk_read

   task automatic chk_stat(input logic [10:0] exp);
      cmp("status", exp, {7'h00, stat_r});
   endtask : chk_stat

   // Results are matched against the oldest note of their kind
   always @(posedge clock) begin
      cyc++;
      if (cyc == 40000) begin
         bad_count++;
         test_done();
      end
      if (frame_valid_r === 1'b1)
         chk_frame(tx_q.size() ? tx_q.pop_front() : 11'h7ff);
      if (rx_rd_valid_r === 1'b1 || rx_rd_nak_r === 1'b1)
         chk_read(rd_q.size() ? rd_q.pop_front() : 11'h7ff);
      if (stat_valid_r === 1'b1)
         chk_stat(st_q.size() ? st_q.pop_front() : 11'h7ff);
   end

   task automatic wr(input logic [7:0] b, input logic ok);
      @(posedge clock);
      #1 tx_wr_valid = 1'b1;
      tx_wr_data = b;
      tx_rpt_ok = ok;
      @(posedge clock);
      while (tx_wr_ready_r !== 1'b1) @(posedge clock);
      #1 tx_wr_valid = 1'b0;
      tx_rpt_ok = 1'b0;
   endtask : wr

   task automatic rep(input logic [7:0] id, input logic w);
      @(posedge clock);
      #1 rpt = '{1'b1, id, w};
      @(posedge clock);
      #1 rpt.valid = 1'b0;
   endtask : rep

   task automatic rd(input logic [10:0] exp);
      rd_q.push_back(exp);
      @(posedge clock);
      #1 rx_rd_req = 1'b1;
      @(posedge clock);
      #1 rx_rd_req = 1'b0;
   endtask : rd

   task automatic setcfg(input logic [3:0] nb, input logic par, input logic odd);
      for (int i = 0; i < 4000 && tx_q.size() > 0; i++) @(posedge clock);
      repeat (2 * BIT) @(posedge clock);
      #1 cfg = '{nb, par, odd, nb[0] & odd, 16'h0000};
   endtask : setcfg

   // One character; wide mode sends data byte then the bit-0 byte with noise above
   task automatic txc(input int nb, input logic par, input logic w, input logic [7:0] d,
                      input logic b1);
      logic [9:0] pl;
      int         n;
      n = (nb == 9 && !w) ? 8 : nb;
      pl = {1'b0, w && nb == 9 && b1, d} & ((10'h001 << n) - 10'h001);
      if (par && nb <= 8) begin
         pl[n] = w ? b1 : (^pl ^ cfg.parity_odd);
         n++;
      end
      nbits = 4'(n);
      tx_q.push_back((11'h001 << n) | 11'(pl));
      wr(d, 1'b1);
      if (w) wr({7'($urandom), b1}, 1'b1);
   endtask : txc

   initial begin
      {soft_reset, bus_reset, tx_rpt_ok, tx_wr_valid, rx_rd_req} = '0;
      reset = 1'b1;
      otp_global_lock = 1'b1;
      tx_wr_data = 8'h00;
      nbits = 4'h8;
      rpt = '0;
      cfg = '{4'h8, 1'b1, 1'b0, 1'b0, 16'h0000};
      void'($urandom(28));
      repeat (5) @(posedge clock);
      #1 reset = 1'b0;
      repeat (2) @(posedge clock);
      cmp("otp_block", 11'h001, {10'h000, otp_wr_block_r});
      #1 otp_global_lock = 1'b0;
      wr(8'ha5, 1'b0);
      for (int w = 0; w < 2; w++) begin
         for (int k = 0; k < 10; k++) begin
            setcfg(4'(5 + k % 5), k >= 5 && k % 5 != 4, k[0]);
            rep(RPT_XFER_MODE, w[0]);
            repeat (2) txc(5 + k % 5, k >= 5 && k % 5 != 4, w[0], 8'($urandom),
                           1'($urandom));
         end
      end
      rd(11'h100);
      setcfg(4'h8, 1'b1, 1'b0);
      u_peer.send({1'b1, 8'h5a}, 9, 1'b1);
      rd(11'h05a);
      rd(11'h001);
      u_peer.send(10'h000, 9, 1'b0);
      rd(11'h000);
      rd(11'h00a);
      st_q.push_back(11'h00b);
      rep(RPT_STATUS, 1'b0);
      setcfg(4'h9, 1'b0, 1'b0);
      u_peer.send({1'b1, 8'hc3}, 9, 1'b1);
      rd(11'h0c3);
      rd(11'h001);
      for (int f = 0; f < 2; f++) begin
         u_peer.send(10'h011, 9, 1'b1);
         @(posedge clock);
         #1 {soft_reset, bus_reset} = f ? 2'b01 : 2'b10;
         rd_q.push_back(11'h100);
         @(posedge clock);
         #1 {soft_reset, bus_reset} = 2'b00;
         rx_rd_req = 1'b1;
         @(posedge clock);
         #1 rx_rd_req = 1'b0;
         cmp("wide_kept", 11'h001, {10'h000, wide_r});
      end
      rep(RPT_XFER_MODE, 1'b0);
      u_peer.send({1'b1, 8'h3e}, 9, 1'b1);
      rd(11'h03e);
      rd(11'h100);
      setcfg(4'h8, 1'b1, 1'b0);
      u_peer.send({1'b1, 8'h81}, 9, 1'b1);
      rd(11'h081);
      rd(11'h100);
      st_q.push_back(11'h001);
      rep(RPT_STATUS, 1'b0);
      st_q.push_back(11'h000);
      rep(RPT_STATUS, 1'b0);
      for (int nb = 5; nb <= 8; nb++) begin
         setcfg(4'(nb), 1'b0, 1'b0);
         tx_wr_data = 8'($urandom);
         u_peer.send({2'b00, tx_wr_data}, nb, 1'b1);
         rd({3'b000, tx_wr_data & 8'((9'h001 << nb) - 9'h001)});
      end
      repeat (4) @(posedge clock);
      cmp("notes_left", 11'h000, 11'(tx_q.size() + rd_q.size() + st_q.size()));
      test_done();
   end
endmodule : hbu_uart_core_test
